// ==== hw/ovk_keyer.sv ====
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
// Notes on behaviour
// - Graphics keyer ANDs key and pixel with the mask, compares for equality.
// - Graphics compare select resets 0; 0 false, 1 true, 4 unequal, 5 equal.
// - Video compare select resets 0, same coding, against video key colour.
// - True and false codes ignore pixel content entirely.
// - Combine codes 0..7: G, false, true, !G, !V, V^G, !G^V, V.
// - Combine codes 8..F: OR and AND forms of G, V and inversions.
// - Inside the window a one shows video, a zero shows graphics.
// - Video-only bit suppresses graphics fetch in the window, shows video.
// - Outside the window graphics is always shown.
// - Window coordinates count from the top-left of active display.
// - 24-bit graphics key and mask are red high byte, blue low.
// - 565 graphics key and mask are blue 4:0, green 10:5, red 15:11.
// - Video keyer ANDs key and pixel with the mask, compares for equality.
// - Video pixel is 24-bit RGB; all 24 key and mask bits apply.
// - Window start and end coordinates are both inclusive.
module ovk_keyer
  import ovk_pkg::*;
#(
  parameter int unsigned PIX_W = 24
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // APB slave
  input  wire logic [ovk_pkg::ADDR_W-1:0] paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Pixel input, active region only
  input  wire logic                pix_valid,
  output logic                     pix_ready,
  input  wire logic                pix_sof,
  input  wire logic                pix_eol,
  input  wire logic [PIX_W-1:0]    gfx_pixel,
  input  wire logic [PIX_W-1:0]    vid_pixel,
  // Graphics fetch control
  output logic                     gfx_fetch_suppress,
  // Display output
  output logic                     disp_valid,
  input  wire logic                disp_ready,
  output logic [PIX_W-1:0]         disp_pixel,
  output logic                     disp_is_video
);
  import ovk_pkg::*;

  // Reset release
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Registers
  logic [31:0]        ctl_reg;
  logic [PIX_W-1:0]   gkey_reg;
  logic [PIX_W-1:0]   gmsk_reg;
  logic [PIX_W-1:0]   vkey_reg;
  logic [PIX_W-1:0]   vmsk_reg;
  logic [31:0]        wst_reg;
  logic [31:0]        wend_reg;
  logic [3:0]         stat_reg;

  // APB decode
  logic [9:0]  idx;
  logic        aligned;
  logic        hit_ctl;
  logic        hit_gkey;
  logic        hit_gmsk;
  logic        hit_vkey;
  logic        hit_vmsk;
  logic        hit_wst;
  logic        hit_wend;
  logic        hit_stat;
  logic        hit_any;
  logic        acc;
  logic        wr;
  logic [31:0] bmask;

  assign idx      = paddr[ADDR_W-1:2];
  assign aligned  = (paddr[1:0] == 2'h0);
  assign hit_ctl  = aligned & (idx == IDX_CONTROL);
  assign hit_gkey = aligned & (idx == IDX_GFX_KEY);
  assign hit_gmsk = aligned & (idx == IDX_GFX_MSK);
  assign hit_vkey = aligned & (idx == IDX_VID_KEY);
  assign hit_vmsk = aligned & (idx == IDX_VID_MSK);
  assign hit_wst  = aligned & (idx == IDX_WIN_START);
  assign hit_wend = aligned & (idx == IDX_WIN_END);
  assign hit_stat = aligned & (idx == IDX_STATUS);
  assign hit_any  = hit_ctl | hit_gkey | hit_gmsk | hit_vkey | hit_vmsk
                  | hit_wst | hit_wend | hit_stat;
  assign acc      = psel & penable;
  assign wr       = acc & pwrite & hit_any;
  assign bmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Zero wait states; unmapped or misaligned words answer with an error
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit_any;

  function automatic logic [31:0] merge(input logic [31:0] old_v);
    merge = (old_v & ~bmask) | (pwdata & bmask);
  endfunction

  logic [31:0] gkey_w;
  logic [31:0] gmsk_w;
  logic [31:0] vkey_w;
  logic [31:0] vmsk_w;

  // Key and mask hold the low 24 bits; red high byte or 565 compact layout
  // Written out, not through merge: a function call would miss pwdata changes
  assign gkey_w = ({{(32-PIX_W){1'b0}}, gkey_reg} & ~bmask) | (pwdata & bmask);
  assign gmsk_w = ({{(32-PIX_W){1'b0}}, gmsk_reg} & ~bmask) | (pwdata & bmask);
  assign vkey_w = ({{(32-PIX_W){1'b0}}, vkey_reg} & ~bmask) | (pwdata & bmask);
  assign vmsk_w = ({{(32-PIX_W){1'b0}}, vmsk_reg} & ~bmask) | (pwdata & bmask);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= RST_CONTROL;
    end else if (wr & hit_ctl) begin
      ctl_reg <= merge(ctl_reg);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gkey_reg <= RST_KEY[PIX_W-1:0];
      gmsk_reg <= RST_KEY[PIX_W-1:0];
      vkey_reg <= RST_KEY[PIX_W-1:0];
      vmsk_reg <= RST_KEY[PIX_W-1:0];
    end else begin
      if (wr & hit_gkey) gkey_reg <= gkey_w[PIX_W-1:0];
      if (wr & hit_gmsk) gmsk_reg <= gmsk_w[PIX_W-1:0];
      if (wr & hit_vkey) vkey_reg <= vkey_w[PIX_W-1:0];
      if (wr & hit_vmsk) vmsk_reg <= vmsk_w[PIX_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wst_reg  <= RST_WIN;
      wend_reg <= RST_WIN;
    end else begin
      if (wr & hit_wst) wst_reg <= merge(wst_reg);
      if (wr & hit_wend) wend_reg <= merge(wend_reg);
    end
  end

  // Control fields
  logic [FN_W-1:0]  vid_compare_select;
  logic [FN_W-1:0]  gfx_compare_select;
  logic [MIX_W-1:0] keyer_combine_select;
  logic             video_only_enable;

  assign vid_compare_select   = ctl_reg[CTL_VID_FN_LSB +: FN_W];
  assign gfx_compare_select   = ctl_reg[CTL_GFX_FN_LSB +: FN_W];
  assign keyer_combine_select = ctl_reg[CTL_MIX_LSB +: MIX_W];
  assign video_only_enable    = ctl_reg[CTL_EXCL_BIT];

  // Read mux; bits above key, mask and status width read zero; control and window bits read back as written
  logic [31:0] rd_data;

  assign rd_data =
      hit_ctl  ? ctl_reg :
      hit_gkey ? {{(32-PIX_W){1'b0}}, gkey_reg} :
      hit_gmsk ? {{(32-PIX_W){1'b0}}, gmsk_reg} :
      hit_vkey ? {{(32-PIX_W){1'b0}}, vkey_reg} :
      hit_vmsk ? {{(32-PIX_W){1'b0}}, vmsk_reg} :
      hit_wst  ? wst_reg :
      hit_wend ? wend_reg :
      hit_stat ? {28'h0000000, stat_reg} : 32'h0000_0000;
  assign prdata = (acc & ~pwrite) ? rd_data : 32'h0000_0000;

  // Screen position within active display
  logic [COORD_W-1:0] x_reg;
  logic [COORD_W-1:0] y_reg;
  logic [COORD_W-1:0] pos_x;
  logic [COORD_W-1:0] pos_y;
  logic [COORD_W-1:0] x_next;
  logic [COORD_W-1:0] y_next;
  logic               accept;

  // Start of frame is (0,0), top-left of the active area
  assign pos_x  = pix_sof ? '0 : x_reg;
  assign pos_y  = pix_sof ? '0 : y_reg;
  assign accept = pix_valid & pix_ready;
  assign x_next = pix_eol ? '0 : pos_x + COORD_W'(1);
  assign y_next = pix_eol ? pos_y + COORD_W'(1) : pos_y;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_reg <= '0;
      y_reg <= '0;
    end else if (accept) begin
      x_reg <= x_next;
      y_reg <= y_next;
    end
  end

  // Window test
  logic [COORD_W-1:0] xs;
  logic [COORD_W-1:0] ys;
  logic [COORD_W-1:0] xe;
  logic [COORD_W-1:0] ye;
  logic               in_win;

  assign xs = wst_reg[WIN_X_LSB +: COORD_W];
  assign ys = wst_reg[WIN_Y_LSB +: COORD_W];
  assign xe = wend_reg[WIN_X_LSB +: COORD_W];
  assign ye = wend_reg[WIN_Y_LSB +: COORD_W];
  assign in_win = (pos_x >= xs) && (pos_x <= xe)
               && (pos_y >= ys) && (pos_y <= ye);

  // Masked compare
  function automatic logic key_cmp(
    input logic [FN_W-1:0]  fn,
    input logic [PIX_W-1:0] pix,
    input logic [PIX_W-1:0] key,
    input logic [PIX_W-1:0] msk
  );
    logic eq;
    eq = ((pix & msk) == (key & msk));
    case (fn)
      CMP_FALSE: key_cmp = 1'b0;
      CMP_TRUE:  key_cmp = 1'b1;
      CMP_NEQ:   key_cmp = ~eq;
      CMP_EQ:    key_cmp = eq;
      default:   key_cmp = 1'b0;
    endcase
  endfunction

  logic gfx_keyer_result;
  logic vid_keyer_result;
  logic g;
  logic v;
  logic mix_res;

  // Same cycle, same position for both keyers
  assign gfx_keyer_result = key_cmp(gfx_compare_select, gfx_pixel,
                                    gkey_reg, gmsk_reg);
  assign vid_keyer_result = key_cmp(vid_compare_select, vid_pixel,
                                    vkey_reg, vmsk_reg);
  assign g = gfx_keyer_result;
  assign v = vid_keyer_result;

  always_comb begin
    case (keyer_combine_select)
      4'h0:    mix_res = g;
      4'h1:    mix_res = 1'b0;
      4'h2:    mix_res = 1'b1;
      4'h3:    mix_res = ~g;
      4'h4:    mix_res = ~v;
      4'h5:    mix_res = v ^ g;
      4'h6:    mix_res = ~g ^ v;
      4'h7:    mix_res = v;
      4'h8:    mix_res = ~g | ~v;
      4'h9:    mix_res = g | ~v;
      4'ha:    mix_res = ~g | v;
      4'hb:    mix_res = g | v;
      4'hc:    mix_res = g & v;
      4'hd:    mix_res = ~g & v;
      4'he:    mix_res = g & ~v;
      4'hf:    mix_res = ~g & ~v;
      default: mix_res = 1'b0;
    endcase
  end

  // Video only inside the window; graphics everywhere else
  logic             sel_video;
  logic [PIX_W-1:0] sel_pixel;

  assign sel_video = in_win & (video_only_enable | mix_res);
  assign sel_pixel = sel_video ? vid_pixel : gfx_pixel;

  // Fetcher looks at the position of the pixel it is about to supply
  assign gfx_fetch_suppress = video_only_enable & in_win;

  // Observable keyer state for the last accepted pixel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= 4'h0;
    end else if (accept) begin
      stat_reg[ST_IN_WIN] <= in_win;
      stat_reg[ST_GFX]    <= gfx_keyer_result;
      stat_reg[ST_VID]    <= vid_keyer_result;
      stat_reg[ST_VIDSEL] <= sel_video;
    end
  end

  // Output buffer; a display stall backs up into pix_ready
  ovk_stream_if #(.W(PIX_W + 1)) buf_in ();
  ovk_stream_if #(.W(PIX_W + 1)) buf_out ();

  assign buf_in.valid  = pix_valid;
  assign buf_in.data   = {sel_video, sel_pixel};
  assign pix_ready     = buf_in.ready;
  assign disp_valid    = buf_out.valid;
  assign buf_out.ready = disp_ready;
  assign disp_pixel    = buf_out.data[PIX_W-1:0];
  assign disp_is_video = buf_out.data[PIX_W];

  ovk_pair_buf #(.W(PIX_W + 1)) u_buf (
    .clk   (clk),
    .rst_n (rst_n),
    .in_s  (buf_in),
    .out_s (buf_out)
  );
endmodule

// ==== hw/ovk_pair_buf.sv ====
`timescale 1ns/1ps
// Two-entry buffer; full registered path, ready never depends on the drain side
module ovk_pair_buf #(
  parameter int unsigned W = 25
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Streams
  ovk_stream_if.snk in_s,
  ovk_stream_if.src out_s
);
  logic [W-1:0] mem_reg [2];
  logic         wp_reg;
  logic         rp_reg;
  logic [1:0]   cnt_reg;
  logic         push;
  logic         pop;

  assign in_s.ready  = (cnt_reg != 2'h2);
  assign out_s.valid = (cnt_reg != 2'h0);
  assign out_s.data  = mem_reg[rp_reg];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) wp_reg <= ~wp_reg;
      if (pop) rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_reg[wp_reg] <= in_s.data;
  end
endmodule

// ==== hw/ovk_pkg.sv ====
package ovk_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_WIN_START = 10'h100;
  localparam logic [9:0]  IDX_WIN_END   = 10'h101;
  localparam logic [9:0]  IDX_VID_KEY   = 10'h102;
  localparam logic [9:0]  IDX_VID_MSK   = 10'h103;
  localparam logic [9:0]  IDX_GFX_KEY   = 10'h104;
  localparam logic [9:0]  IDX_GFX_MSK   = 10'h105;
  localparam logic [9:0]  IDX_CONTROL   = 10'h106;
  localparam logic [9:0]  IDX_STATUS    = 10'h107;
  localparam int unsigned ADDR_W        = 12;

  // Control field layout
  localparam int unsigned CTL_VID_FN_LSB = 0;
  localparam int unsigned CTL_GFX_FN_LSB = 4;
  localparam int unsigned CTL_MIX_LSB    = 8;
  localparam int unsigned CTL_EXCL_BIT   = 24;
  localparam int unsigned FN_W           = 3;
  localparam int unsigned MIX_W          = 4;

  // Window coordinate layout, inclusive bounds
  localparam int unsigned COORD_W   = 11;
  localparam int unsigned WIN_Y_LSB = 0;
  localparam int unsigned WIN_X_LSB = 16;

  // Status bit positions
  localparam int unsigned ST_IN_WIN = 0;
  localparam int unsigned ST_GFX    = 1;
  localparam int unsigned ST_VID    = 2;
  localparam int unsigned ST_VIDSEL = 3;

  // Compare function codes
  localparam logic [2:0] CMP_FALSE = 3'h0;
  localparam logic [2:0] CMP_TRUE  = 3'h1;
  localparam logic [2:0] CMP_NEQ   = 3'h4;
  localparam logic [2:0] CMP_EQ    = 3'h5;

  // Reset values
  localparam logic [31:0] RST_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RST_KEY     = 32'h0000_0000;
  localparam logic [31:0] RST_WIN     = 32'h0000_0000;
endpackage

// ==== hw/ovk_stream_if.sv ====
`timescale 1ns/1ps
interface ovk_stream_if #(
  parameter int unsigned W = 25
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== verification/overlay_colour_keyer_tb_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module overlay_colour_keyer_tb_top;
  import ovk_pkg::*;
  logic              clk, arst_n, psel, penable, pwrite, pix_valid, pix_sof, pix_eol, stall;
  logic              pready, pslverr, pix_ready, gfx_fetch_suppress, disp_valid, disp_is_video;
  logic              disp_ready, err, ex;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, d;
  logic [3:0]        pstrb, s;
  logic [23:0]       gfx_pixel, vid_pixel, disp_pixel, gk, gm, vk, vm;
  logic [24:0]       exp_q[$];
  logic [24:0]       e;
  int                fail_count, cmp_count;
  // Mix truth tables, nibble per code, bit index {gfx, vid}
  localparam logic [63:0] MIX_TAB = 64'h1428ebd7a9653f0c;
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ovk_keyer i_ovk_keyer (.clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_sof(pix_sof), .pix_eol(pix_eol), .gfx_pixel(gfx_pixel), .vid_pixel(vid_pixel),
    .gfx_fetch_suppress(gfx_fetch_suppress), .disp_valid(disp_valid),
    .disp_ready(disp_ready), .disp_pixel(disp_pixel), .disp_is_video(disp_is_video));
  ovk_disp_sink i_ovk_disp_sink (.clk(clk), .stall(stall), .disp_ready(disp_ready));
  function automatic logic cmpf(logic [2:0] fn, logic [23:0] p, logic [23:0] k, logic [23:0] m);
    return (fn == 3'h1) | (fn == 3'h4 && (p & m) != (k & m)) | (fn == 3'h5 && (p & m) == (k & m));
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [3:0] st);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    // Answer taken at the rising edge where pready is seen high
    do @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [31:0] wd);
    apb(1'b1, {i, 2'b00}, wd, 4'hf);
  endtask
  task automatic rchk(input logic [9:0] i, input logic [31:0] ev);
    apb(1'b0, {i, 2'b00}, 32'h0, 4'h0);
    `CHK(rd, ev)
  endtask
  task automatic send(input logic sof, eol, ins, input logic [3:0] m, input logic [2:0] vf, gf);
    logic [23:0] g, v;
    logic        sel;
    g = 24'($urandom);
    v = 24'($urandom);
    if ($urandom_range(0, 1)) g = gk ^ (g & ~gm);
    if ($urandom_range(0, 1)) v = vk ^ (v & ~vm);
    sel = ins & (ex | MIX_TAB[{m, cmpf(gf, g, gk, gm), cmpf(vf, v, vk, vm)}]);
    exp_q.push_back({sel, sel ? v : g});
    pix_valid <= 1'b1;
    pix_sof <= sof;
    pix_eol <= eol;
    gfx_pixel <= g;
    vid_pixel <= v;
    do begin
      @(posedge clk);
      `CHK(gfx_fetch_suppress, ex & ins)
    end while (pix_ready !== 1'b1);
  endtask
  always @(negedge clk) begin
    if (disp_valid === 1'b1 && disp_ready === 1'b1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
      `CHK({disp_is_video, disp_pixel}, e)
    end
  end
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    $display("BAD t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    end_sim();
  end
  initial begin
    {arst_n, psel, penable, pwrite, pix_valid, pix_sof, pix_eol, ex} = '0;
    {paddr, pwdata, pstrb, gfx_pixel, vid_pixel} = '0;
    stall = 1'b1;
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(32'he9f3));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(IDX_CONTROL, RST_CONTROL);
    rchk(IDX_GFX_KEY, RST_KEY);
    rchk(IDX_GFX_MSK, RST_KEY);
    $display("test reset_values done");
    apb(1'b0, 12'h7fc, 32'h0, 4'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    apb(1'b1, {IDX_CONTROL, 2'b01}, 32'hffff_ffff, 4'hf);
    `CHK(err, 1'b1)
    rchk(IDX_CONTROL, 32'h0);
    $display("test refused done");
    {gk, gm, vk, vm} = {$urandom, $urandom, $urandom};
    wr(IDX_GFX_KEY, {8'h0, gk});
    wr(IDX_GFX_MSK, {8'h0, gm});
    wr(IDX_VID_KEY, {8'h0, vk});
    wr(IDX_VID_MSK, {8'h0, vm});
    d = $urandom;
    s = 4'($urandom_range(1, 15));
    apb(1'b1, {IDX_GFX_KEY, 2'b00}, d, s);
    for (int b = 0; b < 3; b++) if (s[b]) gk[8*b +: 8] = d[8*b +: 8];
    rchk(IDX_GFX_KEY, {8'h0, gk});
    rchk(IDX_VID_MSK, {8'h0, vm});
    $display("test keys done");
    wr(IDX_WIN_START, 32'h0001_0001);
    wr(IDX_WIN_END, 32'h0002_0001);
    fork
      begin
        repeat (12) @(posedge clk);
        stall <= 1'b0;
      end
    join_none
    for (int m = 0; m < 16; m++) begin
      ex = (m == 0) ? 1'b0 : 1'($urandom_range(0, 1));
      if (m == 8) begin
        gm = gm & 24'h00ffff;
        wr(IDX_GFX_MSK, {8'h0, gm});
      end
      wr(IDX_CONTROL, {7'h0, ex, 12'h0, 4'(m), 1'b0, 3'(m + 3), 1'b0, 3'(m)});
      for (int y = 0; y < 3; y++)
        for (int x = 0; x < 4; x++)
          send(x == 0 && y == 0, x == 3, x >= 1 && x <= 2 && y == 1, 4'(m), 3'(m), 3'(m + 3));
      pix_valid <= 1'b0;
      $display("test mix %0d done", m);
    end
    for (int i = 0; i < 200 && exp_q.size() != 0; i++) @(posedge clk);
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule

// ==== verification/ovk_disp_sink.sv ====
`timescale 1ns/1ps
module ovk_disp_sink (
  // Clock and stall control
  input wire logic clk,
  input wire logic stall,
  // Display handshake
  output logic     disp_ready
);
  // Random back-pressure so the buffer meets stalls mid-frame
  initial begin
    disp_ready = 1'b0;
    forever @(posedge clk) disp_ready <= !stall && ($urandom_range(0, 3) != 0);
  end
endmodule

// ==== verification/ovk_keyer_properties.sv ====
`timescale 1ns/1ps
module ovk_keyer_properties
  import ovk_pkg::*;
#(
  parameter int unsigned PIX_W = 24
) (
  // Clock and reset
  input wire logic                       clk,
  input wire logic                       arst_n,
  // APB
  input wire logic [ovk_pkg::ADDR_W-1:0] paddr,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [31:0]                pwdata,
  input wire logic [3:0]                 pstrb,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // Pixel streams
  input wire logic                       pix_valid,
  input wire logic                       pix_ready,
  input wire logic                       pix_sof,
  input wire logic                       pix_eol,
  input wire logic [PIX_W-1:0]           gfx_pixel,
  input wire logic [PIX_W-1:0]           vid_pixel,
  input wire logic                       gfx_fetch_suppress,
  input wire logic                       disp_valid,
  input wire logic                       disp_ready,
  input wire logic [PIX_W-1:0]           disp_pixel,
  input wire logic                       disp_is_video
);
  import ovk_pkg::*;
  logic       excl_reg;
  logic [1:0] fill_reg;
  wire        wr_ctl = psel & penable & pwrite & pstrb[3] & (paddr == {IDX_CONTROL, 2'b00});
  wire        take_in = pix_valid & pix_ready;
  wire        take_out = disp_valid & disp_ready;
  // Shadow of the video-only bit and of buffer occupancy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      excl_reg <= 1'b0;
      fill_reg <= 2'd0;
    end else begin
      if (wr_ctl) excl_reg <= pwdata[CTL_EXCL_BIT];
      fill_reg <= fill_reg + 2'(take_in) - 2'(take_out);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_stall;
    disp_valid && !disp_ready;
  endsequence
  a_pready_high: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (s_access ##0 (paddr[1:0] != 2'b00 || paddr[11:2] == 10'h1ff)
    |-> pslverr) else $error("no error on bad address");
  a_ctl_mapped: assert property (s_access ##0 (paddr == {IDX_CONTROL, 2'b00}) |-> !pslverr)
    else $error("error on control access");
  a_err_rzero: assert property (s_access ##0 (!pwrite && pslverr) |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_idle_quiet: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
  a_disp_hold: assert property (s_stall |=> disp_valid && $stable(disp_pixel)
    && $stable(disp_is_video)) else $error("display word changed while stalled");
  a_ready_full: assert property (pix_ready == (fill_reg != 2'd2))
    else $error("input ready does not follow occupancy");
  a_first_latency: assert property (take_in && fill_reg == 2'd0 |=> disp_valid)
    else $error("pixel not presented next cycle");
  a_fetch_off: assert property (!excl_reg |-> !gfx_fetch_suppress)
    else $error("fetch suppressed in normal mode");
endmodule
bind ovk_keyer ovk_keyer_properties #(.PIX_W(PIX_W)) i_ovk_keyer_properties (
  .clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_sof(pix_sof),
  .pix_eol(pix_eol), .gfx_pixel(gfx_pixel), .vid_pixel(vid_pixel),
  .gfx_fetch_suppress(gfx_fetch_suppress), .disp_valid(disp_valid),
  .disp_ready(disp_ready), .disp_pixel(disp_pixel), .disp_is_video(disp_is_video));
